/* File: rtl/rpr_pkg.sv */
// Purpose: Shared constants for the radio power and reset controller
// Assumes: Single 100 MHz core clock
// Notes:   Host clock limits are kept for reference by checkers
package rpr_pkg;

  localparam int unsigned CORE_CLK_HZ      = 100_000_000;
  localparam int unsigned SYNC_STAGES      = 2;
  localparam logic        PULL_EN_RESET    = 1'b1;
  localparam logic        PULL_DIS_RESET   = 1'b0;
  localparam logic        SECTION_RST_INIT = 1'b1;
  localparam logic        REG_EN_INIT      = 1'b0;

  // Host-side clock limits per speed mode, in their own units
  localparam int unsigned DEF_XFER_MAX_MHZ   = 25;
  localparam int unsigned ID_MAX_KHZ         = 400;
  localparam int unsigned HS_XFER_MAX_MHZ    = 50;
  localparam int unsigned SDR_SLOW_MIN_PS    = 40_000;
  localparam int unsigned SDR_MID_MIN_PS     = 20_000;
  localparam int unsigned SDR_FAST_MIN_PS    = 12_500;
  localparam int unsigned SDR_DUTY_MIN_PCT   = 30;
  localparam int unsigned SDR_DUTY_MAX_PCT   = 70;
  localparam int unsigned DDR_MIN_PS         = 25_000;
  localparam int unsigned DDR_DUTY_MIN_PCT   = 45;
  localparam int unsigned DDR_DUTY_MAX_PCT   = 55;

endpackage : rpr_pkg

/* File: rtl/rpr_sect_if.sv */
// Purpose: Carrier between top and per-section controller
// Assumes: One clock domain
// Notes:   Top drives enables, section reports state
`timescale 1ns/100ps
interface rpr_sect_if;
  logic enable_sync;
  logic pull_override;
  logic section_rst;
  logic pull_en;

  modport ctrl
  (
    input  enable_sync,
    input  pull_override,
    output section_rst,
    output pull_en
  );
  modport top
  (
    output enable_sync,
    output pull_override,
    input  section_rst,
    input  pull_en
  );
endinterface : rpr_sect_if

/* File: rtl/rpr_section_ctrl.sv */
// Purpose: Reset and pull-down control for one radio section
// Assumes: Enable already synchronised
// Notes:   Pull-down latches off on first high, until reset
`timescale 1ns/100ps
module rpr_section_ctrl
  import rpr_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  rpr_sect_if.ctrl   sect
);

  logic seen_high_reg;
  logic rst_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_reg <= SECTION_RST_INIT;
    else
      rst_reg <= ~sect.enable_sync;
  end

  // Sticky: the pull stays off once a high was recognised
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      seen_high_reg <= 1'b0;
    else if (sect.enable_sync)
      seen_high_reg <= 1'b1;
  end

  assign sect.section_rst = rst_reg;
  assign sect.pull_en     = ~seen_high_reg & ~sect.enable_sync
                            & ~sect.pull_override;

endmodule : rpr_section_ctrl

/* File: rtl/rpr_power_ctrl.sv */
// Purpose: Power and reset control for the WLAN and Bluetooth sections
// Assumes: Enable pins are asynchronous to core_clk
// Notes:   All outputs registered; two-stage sync on both pins
//
// Contract
// [R1] Regulators on when either enable high
// [R2] WLAN reset follows WLAN enable low
// [R3] Bluetooth reset follows Bluetooth enable low
// [R4] Regulators off only when both low
// [R5] Pull-down on until a high is seen
// [R6] Software input can turn pull-down off
// [R7] Host treats sequence intervals as minimums
// [R8] Default mode clock limits for host
// [R9] High-speed mode clock limits for host
// [R10] Single-rate clock period and duty limits
// [R11] Double-rate clock period and duty limits
// [R12] Enables synchronised before driving resets
`timescale 1ns/100ps
module rpr_power_ctrl
  import rpr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic wlan_section_enable,
  input  wire logic bluetooth_section_enable,
  input  wire logic wlan_pull_disable,
  input  wire logic bluetooth_pull_disable,
  output logic      regulator_enable,
  output logic      wlan_section_rst,
  output logic      bluetooth_section_rst,
  output logic      wlan_pull_en,
  output logic      bluetooth_pull_en
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers: first stage feeds only the second

  logic [1:0] en_meta_reg;
  logic [1:0] en_sync_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_meta_reg <= 2'h0;
      en_sync_reg <= 2'h0;
    end
    else
    begin
      en_meta_reg <= {bluetooth_section_enable, wlan_section_enable}; // R12
      en_sync_reg <= en_meta_reg;                                    // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-section control

  rpr_sect_if wl_if ();
  rpr_sect_if bt_if ();

  assign wl_if.enable_sync   = en_sync_reg[0];
  assign bt_if.enable_sync   = en_sync_reg[1];
  assign wl_if.pull_override = wlan_pull_disable;      // R6
  assign bt_if.pull_override = bluetooth_pull_disable; // R6

  rpr_section_ctrl u_wlan
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sect     (wl_if)
  );

  rpr_section_ctrl u_bt
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sect     (bt_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  logic reg_en_reg;
  logic wl_pull_reg;
  logic bt_pull_reg;

  // OR of both sections; reset and regulator off change on the same edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_en_reg <= REG_EN_INIT;
    else
      reg_en_reg <= en_sync_reg[0] | en_sync_reg[1]; // R1 R4
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wl_pull_reg <= PULL_EN_RESET;
      bt_pull_reg <= PULL_EN_RESET;
    end
    else
    begin
      wl_pull_reg <= wl_if.pull_en; // R5
      bt_pull_reg <= bt_if.pull_en; // R5
    end
  end

  assign regulator_enable      = reg_en_reg;
  assign wlan_section_rst      = wl_if.section_rst; // R2
  assign bluetooth_section_rst = bt_if.section_rst; // R3
  assign wlan_pull_en          = wl_pull_reg;
  assign bluetooth_pull_en     = bt_pull_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Three samples high clear the two sync stages and the output flop
  a_reg_en_or: assert property // R1
    ((wlan_section_enable || bluetooth_section_enable)[*3]
     |=> regulator_enable)
    else $error("reg enable or");
  a_reg_on_either: assert property // R1
    ($past(en_sync_reg[0]) || $past(en_sync_reg[1]) |-> regulator_enable)
    else $error("regulator not on");
  a_reg_off_both: assert property // R4
    (!$past(en_sync_reg[0]) && !$past(en_sync_reg[1]) |-> !regulator_enable)
    else $error("regulator not off");
  a_wlan_rst_follow: assert property // R2
    ($rose(wlan_section_enable) ##1 wlan_section_enable[*2]
     |-> ##1 !wlan_section_rst)
    else $error("wlan reset not released");
  a_bt_rst_follow: assert property // R3
    ($fell(bluetooth_section_enable) ##1 !bluetooth_section_enable[*2]
     |-> ##1 bluetooth_section_rst)
    else $error("bt reset not asserted");
  a_wl_pull_off: assert property // R5
    (wlan_section_rst ##1 !wlan_section_rst |-> ##[1:2] !wlan_pull_en)
    else $error("wlan pull still on");
  // Once a section left reset its pin was seen high: pull stays off
  a_bt_pull_stay: assert property // R5
    (!bluetooth_section_rst |=> !bluetooth_pull_en)
    else $error("bt pull came back");
  a_wl_pull_stay: assert property // R5
    (!wlan_section_rst |=> !wlan_pull_en)
    else $error("wlan pull came back");
  a_pull_override: assert property // R6
    (wlan_pull_disable |=> !wlan_pull_en)
    else $error("override ignored");
  a_bt_override: assert property // R6
    (bluetooth_pull_disable |=> !bluetooth_pull_en)
    else $error("bt override ignored");
  a_sync_delay: assert property // R12
    ($rose(en_sync_reg[1]) |-> $past(bluetooth_section_enable, 2))
    else $error("sync bypassed");

  c_wl_up:   cover property ($fell(wlan_section_rst));
  c_bt_up:   cover property ($fell(bluetooth_section_rst));
  c_both_on: cover property (!wlan_section_rst && !bluetooth_section_rst);
  c_reg_off: cover property ($fell(regulator_enable));

endmodule : rpr_power_ctrl

/* File: tb/rpr_host_model.sv */
// Purpose: Host model driving the two section enable pins
// Assumes: Requests come from the bench on core_clk
// Notes:   A level is kept at least MIN_DWELL cycles; longer is legal
`timescale 1ns/100ps
module rpr_host_model
#(
  parameter int      MIN_DWELL = 4,
  parameter realtime SDIO_HALF = 20.0
)
(
  input  wire logic       core_clk,
  input  wire logic [1:0] req,
  output logic [1:0]      pins = 2'b00,
  output logic            sdio_clk = 1'b0
);
  int dwell = 0;
  // Host clock: 40 ns period, even duty, within every speed mode except the 400 kHz ID limit
  always #(SDIO_HALF) sdio_clk = ~sdio_clk;
  always @(posedge core_clk)
  begin
    dwell <= dwell + 1;
    if (req != pins && dwell >= MIN_DWELL)
    begin
      pins  <= req;
      dwell <= 0;
    end
  end
endmodule : rpr_host_model

/* File: tb/rpr_power_ctrl_test.sv */
// Purpose: Self-checking bench for the power and reset controller
// Assumes: Outputs settle within three edges of a pin change
// Notes:   Random pin and pull-disable mix after fixed corners
`timescale 1ns/100ps
module rpr_power_ctrl_test
  import rpr_pkg::*;
;
  logic core_clk = 0, rst_n = 0, wd = 0, bd = 0, sw = 0, sb = 0;
  logic [1:0] req = 2'b00, pins;
  logic sdio_clk;
  realtime t_rise, t_fall, t_next, per_ps, duty;
  logic reg_en, w_rst, b_rst, w_pull, b_pull;
  int miscompares = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  rpr_host_model i_host (.core_clk(core_clk), .req(req), .pins(pins),
    .sdio_clk(sdio_clk));
  rpr_power_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .wlan_section_enable(pins[1]), .bluetooth_section_enable(pins[0]),
    .wlan_pull_disable(wd), .bluetooth_pull_disable(bd),
    .regulator_enable(reg_en), .wlan_section_rst(w_rst),
    .bluetooth_section_rst(b_rst), .wlan_pull_en(w_pull),
    .bluetooth_pull_en(b_pull));
  ////////////////////////////////////////////////////////////////////
  // Pull-down stays off once a high was seen, until reset
  function automatic logic exp_pull(logic seen, logic dis);
    return ~(seen | dis);
  endfunction : exp_pull
  task automatic check(string name, logic got, logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %b seen %b", name, exp, got);
      miscompares++;
    end
  endtask : check
  task automatic step(logic [1:0] r, logic dw, logic db);
    @(posedge core_clk);
    req <= r;
    wd  <= dw;
    bd  <= db;
    repeat (10) @(posedge core_clk);
    #1;
    sw |= r[1];
    sb |= r[0];
    check("regulator_enable", reg_en, r[1] | r[0]);
    check("regulator_off", ~reg_en, ~r[1] & ~r[0]);
    check("wlan_section_rst", w_rst, ~r[1]);
    check("bluetooth_section_rst", b_rst, ~r[0]);
    check("wlan_pull_en", w_pull, exp_pull(sw, dw));
    check("bluetooth_pull_en", b_pull, exp_pull(sb, db));
  endtask : step
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    void'($urandom(55));
    repeat (16) @(posedge core_clk);
    rst_n <= 1;
    step(2'b00, 0, 1);
    step(2'b00, 0, 0);
    step(2'b10, 0, 0);
    step(2'b11, 0, 0);
    step(2'b01, 0, 0);
    step(2'b00, 0, 0);
    // Mid-run reset re-arms both pull-downs
    @(posedge core_clk);
    rst_n <= 0;
    repeat (2) @(posedge core_clk);
    #1;
    check("rst_regulator", reg_en, 1'b0);
    check("rst_wlan", w_rst, 1'b1);
    check("rst_bt_pull", b_pull, 1'b1);
    @(posedge core_clk);
    rst_n <= 1;
    sw = 0;
    sb = 0;
    repeat (40)
      step(2'($urandom), 1'($urandom), 1'($urandom));
    @(posedge sdio_clk) t_rise = $realtime;
    @(negedge sdio_clk) t_fall = $realtime;
    @(posedge sdio_clk) t_next = $realtime;
    per_ps = (t_next - t_rise) * 1000.0;
    duty = (t_fall - t_rise) * 100.0 / (t_next - t_rise);
    check("sdio_def", per_ps >= 1.0e6 / DEF_XFER_MAX_MHZ, 1'b1);
    check("sdio_hs", per_ps >= 1.0e6 / HS_XFER_MAX_MHZ, 1'b1);
    check("sdio_sdr", per_ps >= SDR_SLOW_MIN_PS, 1'b1);
    check("sdio_sdr_duty", duty >= SDR_DUTY_MIN_PCT
      && duty <= SDR_DUTY_MAX_PCT, 1'b1);
    check("sdio_ddr", per_ps >= DDR_MIN_PS, 1'b1);
    check("sdio_ddr_duty", duty >= DDR_DUTY_MIN_PCT
      && duty <= DDR_DUTY_MAX_PCT, 1'b1);
    complete_run();
  end
endmodule : rpr_power_ctrl_test
